/* src/adc_ctrl_pkg.sv */
// Purpose: Shared constants for the converter control block.
// Assumes: 100 MHz ref_clk, 32-bit AHB-Lite register bus.
// Notes:   Register offsets are byte addresses of aligned words.
package adc_ctrl_pkg;

    // Register byte offsets.
    localparam logic [7:0] MODE_OFS   = 8'h00;
    localparam logic [7:0] CHSEL_OFS  = 8'h04;
    localparam logic [7:0] RESULT_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;
    localparam logic [7:0] MASK_OFS   = 8'h10;

    // Mode register fields.
    localparam int RUN_BIT    = 7;
    localparam int FR_MSB     = 5;
    localparam int FR_LSB     = 3;
    localparam int CMP_EN_BIT = 0;

    // Status and mask register fields.
    localparam int FLAG_BIT    = 0;
    localparam int SUSPECT_BIT = 1;
    localparam int BUSY_BIT    = 8;
    localparam int SETTLED_BIT = 9;

    // Reset values.
    localparam logic [7:0] MODE_RST  = 8'h00;
    localparam logic [1:0] CHSEL_RST = 2'h0;
    localparam logic [9:0] RESULT_RST = 10'h000;
    localparam logic [1:0] MASK_RST  = 2'h0;

    // Converter geometry.
    localparam int RES_BITS  = 10;
    localparam int CH_BITS   = 2;
    // A conversion period is 12 units: 2 units sampling, 10 bit trials.
    localparam logic [1:0] SAMPLE_UNITS = 2'h2;
    localparam int PERIOD_UNITS = 12;
    // Unit length is (conversion-time field + 1) times this many cycles.
    localparam logic [6:0] UNIT_CYCLES = 7'h08;

    // Comparator settling time after enable.
    localparam int CLK_MHZ        = 100;
    localparam int SETTLE_US      = 14;
    localparam int SETTLE_CYCLES  = SETTLE_US * CLK_MHZ;

    typedef enum logic [1:0] {
        SAR_IDLE,
        SAR_SAMPLE,
        SAR_CONVERT
    } sar_state_t;

endpackage

/* src/sar_core.sv */
// Purpose: Successive-approximation sequencer for one conversion stream.
// Assumes: cmp_in is already synchronised to ref_clk.
// Notes:   Converts back to back while run is high.
`timescale 1ns/100ps
module sar_core
(
    // Clock and reset.
    input  wire logic                ref_clk,
    input  wire logic                rst_b,
    // Control.
    input  wire logic                run,
    input  wire logic [2:0]          fr,
    input  wire logic [1:0]          chan,
    input  wire logic                cmp_in,
    // Analog side.
    output logic                     sample_reg,
    output logic [1:0]               chan_reg,
    output logic [9:0]               dac_reg,
    // Results.
    output logic                     done_reg,
    output logic [9:0]               result_reg,
    output logic                     busy_reg
);

    adc_ctrl_pkg::sar_state_t state_reg;
    adc_ctrl_pkg::sar_state_t state_next;
    logic [6:0] unit_len;
    logic [6:0] div_reg;
    logic [6:0] div_next;
    logic       unit_tick;
    logic [3:0] step_reg;
    logic [3:0] step_next;
    logic [1:0] chan_next;
    logic [9:0] dac_next;
    logic       done_next;
    logic [9:0] result_next;

    assign unit_len = 7'(({4'h0, fr} + 7'h01) * adc_ctrl_pkg::UNIT_CYCLES);
    assign unit_tick = (state_reg != adc_ctrl_pkg::SAR_IDLE)
                       && (div_reg == 7'h00);

    always_comb
    begin
        state_next  = state_reg;
        div_next    = (div_reg == 7'h00) ? unit_len - 7'h01 : div_reg - 7'h01;
        step_next   = step_reg;
        chan_next   = chan_reg;
        dac_next    = dac_reg;
        done_next   = 1'b0;
        result_next = result_reg;
        case (state_reg)
            adc_ctrl_pkg::SAR_IDLE:
            begin
                div_next = unit_len - 7'h01;
                if (run)
                begin
                    // Channel is latched here, so a later select change
                    // only takes effect on the next conversion.
                    state_next = adc_ctrl_pkg::SAR_SAMPLE;
                    step_next  = {2'h0, adc_ctrl_pkg::SAMPLE_UNITS} - 4'h1;
                    chan_next  = chan;
                end
            end
            adc_ctrl_pkg::SAR_SAMPLE:
            begin
                if (unit_tick)
                begin
                    if (step_reg == 4'h0)
                    begin
                        // Two of twelve units sample the input.
                        state_next = adc_ctrl_pkg::SAR_CONVERT;
                        step_next  = 4'(adc_ctrl_pkg::RES_BITS - 1);
                        dac_next   = 10'h200;
                    end
                    else
                    begin
                        step_next = step_reg - 4'h1;
                    end
                end
            end
            adc_ctrl_pkg::SAR_CONVERT:
            begin
                if (unit_tick)
                begin
                    // Keep the trial bit when the input is above the DAC,
                    // then try the next lower bit.
                    if (!cmp_in)
                    begin
                        dac_next[step_reg] = 1'b0;
                    end
                    if (step_reg == 4'h0)
                    begin
                        done_next   = 1'b1;
                        result_next = dac_next;
                        state_next  = adc_ctrl_pkg::SAR_SAMPLE;
                        step_next   = {2'h0, adc_ctrl_pkg::SAMPLE_UNITS}
                                      - 4'h1;
                        chan_next   = chan;
                    end
                    else
                    begin
                        step_next = step_reg - 4'h1;
                        dac_next[step_reg - 4'h1] = 1'b1;
                    end
                end
            end
            default:
            begin
                state_next = adc_ctrl_pkg::SAR_IDLE;
            end
        endcase
        // Clearing run abandons any conversion in flight.
        if (!run)
        begin
            state_next = adc_ctrl_pkg::SAR_IDLE;
            done_next  = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg  <= adc_ctrl_pkg::SAR_IDLE;
            div_reg    <= 7'h00;
            step_reg   <= 4'h0;
            chan_reg   <= 2'h0;
            dac_reg    <= 10'h000;
            done_reg   <= 1'b0;
            result_reg <= 10'h000;
            sample_reg <= 1'b0;
            busy_reg   <= 1'b0;
        end
        else
        begin
            state_reg  <= state_next;
            div_reg    <= div_next;
            step_reg   <= step_next;
            chan_reg   <= chan_next;
            dac_reg    <= dac_next;
            done_reg   <= done_next;
            result_reg <= result_next;
            sample_reg <= (state_next == adc_ctrl_pkg::SAR_SAMPLE);
            busy_reg   <= (state_next != adc_ctrl_pkg::SAR_IDLE);
        end
    end

    // Helper: length of each sampling window in cycles.
    logic [7:0] samp_cnt_reg;
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            samp_cnt_reg <= 8'h00;
        else if (sample_reg)
            samp_cnt_reg <= samp_cnt_reg + 8'h01;
        else
            samp_cnt_reg <= 8'h00;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_sample_share: assert property (
        ($fell(sample_reg) && $past(run) && run && $stable(fr))
        |-> samp_cnt_reg == 8'({1'b0, unit_len} * 8'h02))
        else $error("sampling window is not one sixth of the period");

    a_run_stops: assert property (
        !run |=> !busy_reg && !done_reg)
        else $error("converter kept running with run cleared");

endmodule

/* src/adc_sequencing_control.sv */
// Purpose: Register file, priority and interrupt logic of the converter.
// Assumes: Sole AHB-Lite slave; word accesses only; comparator_in is asynchronous.
// Notes:   Zero wait states; every response is OKAY.
//
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps
module adc_sequencing_control
(
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Analog front end.
    input  wire logic        comparator_in,
    output logic             sample_hold,
    output logic      [1:0]  analog_input_channels,
    output logic      [9:0]  dac_code,
    output logic             comparator_enable_bit,
    // Interrupts.
    output logic             conversion_end_irq,
    output logic             irq
);

    logic        cmp_meta_reg;
    logic        cmp_sync_reg;
    logic [7:0]  converter_mode_reg;
    logic [7:0]  mode_next;
    logic [1:0]  channel_select_reg;
    logic [1:0]  chsel_next;
    logic [9:0]  conversion_result_reg;
    logic [9:0]  result_next;
    logic        conversion_irq_flag;
    logic        flag_next;
    logic        suspect_reg;
    logic        suspect_next;
    logic [1:0]  mask_reg;
    logic [1:0]  mask_next;
    logic [10:0] settle_reg;
    logic [10:0] settle_next;
    logic        settled;
    logic        wr_pend_reg;
    logic [7:0]  wr_addr_reg;
    logic [31:0] hrdata_next;
    logic        addr_ok;
    logic        rd_accept;
    logic        mode_wr;
    logic        chsel_wr;
    logic        stat_wr;
    logic        mask_wr;
    logic        cfg_wr;
    logic        accept_done;
    logic        irq_next;
    logic        core_done;
    logic [9:0]  core_result;
    logic        core_busy;
    logic        core_sample;
    logic [1:0]  core_chan;
    logic [9:0]  core_dac;

    // The comparator output is analog-timed, so it is synchronised first.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cmp_meta_reg <= 1'b0;
            cmp_sync_reg <= 1'b0;
        end
        else
        begin
            cmp_meta_reg <= comparator_in;
            cmp_sync_reg <= cmp_meta_reg;
        end
    end

    sar_core u_sar_core
    (
        .ref_clk    (ref_clk),
        .rst_b      (rst_b),
        .run        (converter_mode_reg[adc_ctrl_pkg::RUN_BIT]),
        .fr         (converter_mode_reg[adc_ctrl_pkg::FR_MSB:
                                        adc_ctrl_pkg::FR_LSB]),
        .chan       (channel_select_reg),
        .cmp_in     (cmp_sync_reg),
        .sample_reg (core_sample),
        .chan_reg   (core_chan),
        .dac_reg    (core_dac),
        .done_reg   (core_done),
        .result_reg (core_result),
        .busy_reg   (core_busy)
    );

    // hsize is not decoded: only whole-word transfers are supported.
    assign addr_ok   = hsel && htrans[1] && hready;
    assign rd_accept = addr_ok && !hwrite;
    assign mode_wr   = wr_pend_reg && (wr_addr_reg == adc_ctrl_pkg::MODE_OFS);
    assign chsel_wr  = wr_pend_reg && (wr_addr_reg == adc_ctrl_pkg::CHSEL_OFS);
    assign stat_wr   = wr_pend_reg
                       && (wr_addr_reg == adc_ctrl_pkg::STATUS_OFS);
    assign mask_wr   = wr_pend_reg && (wr_addr_reg == adc_ctrl_pkg::MASK_OFS);
    assign cfg_wr    = mode_wr || chsel_wr;
    // A configuration write in the completion cycle discards the result.
    assign accept_done = core_done && !cfg_wr;
    assign settled     = (settle_reg == 11'(adc_ctrl_pkg::SETTLE_CYCLES));

    always_comb
    begin
        mode_next   = converter_mode_reg;
        chsel_next  = channel_select_reg;
        mask_next   = mask_reg;
        settle_next = settle_reg;
        if (mode_wr)
        begin
            // Bit 7 runs, bits 5:3 pick the period, bit 0 powers.
            mode_next = hwdata[7:0] & 8'hB9;
        end
        if (chsel_wr)
        begin
            chsel_next = hwdata[1:0];
        end
        if (mask_wr)
        begin
            mask_next = hwdata[1:0];
        end
        if (!converter_mode_reg[adc_ctrl_pkg::CMP_EN_BIT])
        begin
            settle_next = 11'h000;
        end
        else if (!settled)
        begin
            settle_next = settle_reg + 11'h001;
        end
    end

    always_comb
    begin
        // A read sampled in this cycle captured the old value already.
        result_next = accept_done ? core_result : conversion_result_reg;
        // Set wins over a write-one clear; a channel write never clears.
        flag_next = accept_done
                    || (conversion_irq_flag
                        && !(stat_wr && hwdata[adc_ctrl_pkg::FLAG_BIT]));
        // Run rising before the comparator has settled.
        suspect_next = (mode_wr && hwdata[adc_ctrl_pkg::RUN_BIT]
                        && !converter_mode_reg[adc_ctrl_pkg::RUN_BIT]
                        && !(converter_mode_reg[adc_ctrl_pkg::CMP_EN_BIT]
                             && settled))
                       || (suspect_reg
                           && !(stat_wr && hwdata[adc_ctrl_pkg::SUSPECT_BIT]));
        irq_next = |({suspect_next, flag_next} & mask_next);
        hrdata_next = 32'h0000_0000;
        case (haddr[7:0])
            adc_ctrl_pkg::MODE_OFS:   hrdata_next[7:0] = converter_mode_reg;
            adc_ctrl_pkg::CHSEL_OFS:  hrdata_next[1:0] = channel_select_reg;
            adc_ctrl_pkg::RESULT_OFS: hrdata_next[9:0] = conversion_result_reg;
            adc_ctrl_pkg::STATUS_OFS:
            begin
                hrdata_next[adc_ctrl_pkg::FLAG_BIT]    = conversion_irq_flag;
                hrdata_next[adc_ctrl_pkg::SUSPECT_BIT] = suspect_reg;
                hrdata_next[adc_ctrl_pkg::BUSY_BIT]    = core_busy;
                hrdata_next[adc_ctrl_pkg::SETTLED_BIT] = settled;
            end
            adc_ctrl_pkg::MASK_OFS:   hrdata_next[1:0] = mask_reg;
            default:                  hrdata_next = 32'h0000_0000;
        endcase
        if (!rd_accept || (haddr[31:8] != 24'h00_0000))
        begin
            hrdata_next = 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            converter_mode_reg    <= adc_ctrl_pkg::MODE_RST;
            channel_select_reg    <= adc_ctrl_pkg::CHSEL_RST;
            conversion_result_reg <= adc_ctrl_pkg::RESULT_RST;
            mask_reg              <= adc_ctrl_pkg::MASK_RST;
            conversion_irq_flag   <= 1'b0;
            suspect_reg           <= 1'b0;
            settle_reg            <= 11'h000;
            wr_pend_reg           <= 1'b0;
            wr_addr_reg           <= 8'h00;
            hrdata                <= 32'h0000_0000;
            hreadyout             <= 1'b0;
            hresp                 <= 1'b0;
            conversion_end_irq    <= 1'b0;
            irq                   <= 1'b0;
            sample_hold           <= 1'b0;
            analog_input_channels <= 2'h0;
            dac_code              <= 10'h000;
            comparator_enable_bit <= 1'b0;
        end
        else
        begin
            converter_mode_reg    <= mode_next;
            channel_select_reg    <= chsel_next;
            conversion_result_reg <= result_next;
            mask_reg              <= mask_next;
            conversion_irq_flag   <= flag_next;
            suspect_reg           <= suspect_next;
            settle_reg            <= settle_next;
            wr_pend_reg           <= addr_ok && hwrite
                                     && (haddr[31:8] == 24'h00_0000);
            wr_addr_reg           <= haddr[7:0];
            hrdata                <= hrdata_next;
            hreadyout             <= 1'b1;
            hresp                 <= 1'b0;
            conversion_end_irq    <= accept_done;
            irq                   <= irq_next;
            sample_hold           <= core_sample;
            analog_input_channels <= core_chan;
            dac_code              <= core_dac;
            comparator_enable_bit <= mode_next[adc_ctrl_pkg::CMP_EN_BIT];
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence s_result_read;
        rd_accept && (haddr[7:0] == adc_ctrl_pkg::RESULT_OFS)
        && (haddr[31:8] == 24'h00_0000);
    endsequence

    sequence s_cfg_collision;
        core_done && cfg_wr;
    endsequence

    a_read_first: assert property (
        (s_result_read and core_done)
        |=> (hrdata[9:0] == $past(conversion_result_reg))
            && (conversion_result_reg == $past(core_result)))
        else $error("colliding read did not return the old result");

    a_write_wins: assert property (
        s_cfg_collision
        |=> $stable(conversion_result_reg) && !conversion_end_irq)
        else $error("colliding config write did not discard the result");

    a_write_no_flag: assert property (
        (s_cfg_collision and !conversion_irq_flag) ##1 !core_done
        |-> !conversion_irq_flag)
        else $error("discarded conversion set the flag");

    a_chsel_keeps_flag: assert property (
        chsel_wr && !core_done |=> $stable(conversion_irq_flag))
        else $error("channel write changed the interrupt flag");

    a_normal_end: assert property (
        core_done && !cfg_wr
        |=> conversion_end_irq && conversion_irq_flag
            && (conversion_result_reg == $past(core_result)))
        else $error("normal conversion end not stored with its interrupt");

    a_unsettled_start: assert property (
        mode_wr && hwdata[adc_ctrl_pkg::RUN_BIT]
        && !converter_mode_reg[adc_ctrl_pkg::RUN_BIT] && !settled
        |=> suspect_reg)
        else $error("early start did not mark the first result");

    a_irq_level: assert property (
        ##1 (irq == |({suspect_reg, conversion_irq_flag} & mask_reg)))
        else $error("interrupt output disagrees with status and mask");

    a_run_bit: assert property (
        !converter_mode_reg[adc_ctrl_pkg::RUN_BIT] ##1 $stable(mode_next)
        |-> !core_done ##1 !conversion_end_irq)
        else $error("conversion ended with the run bit clear");

endmodule

/* tb/analog_inputs_model.sv */
// Purpose: Behavioural model of the four analog inputs and comparator.
// Assumes: The bench holds each level steady during bit trials.
// Notes:   A disabled comparator gives a toggling, meaningless output.
`timescale 1ns/100ps
module analog_inputs_model
(
    // Clock.
    input  wire logic            ref_clk,
    // Converter side.
    input  wire logic [1:0]      analog_input_channels,
    input  wire logic [9:0]      dac_code,
    input  wire logic            comparator_enable_bit,
    // Input levels, one 10-bit code per channel.
    input  wire logic [3:0][9:0] levels,
    output logic                 comparator_in
);
    logic junk_reg = 1'b0;

    // An unpowered comparator must never look like a steady answer.
    always_ff @(posedge ref_clk)
        junk_reg <= ~junk_reg;

    // Nothing here touches the shared port pins during a conversion.
    always_comb
        comparator_in = comparator_enable_bit
            ? (levels[analog_input_channels] >= dac_code) : junk_reg;
endmodule

/* tb/test_adc_sequencing_control.sv */
// Purpose: Self-checking bench for the converter control block.
// Assumes: Zero wait-state slave; back-to-back conversions while running.
// Notes:   Collision cases are timed from the measured conversion period.
`timescale 1ns/100ps
module test_adc_sequencing_control;
    logic            ref_clk = 1'b0;
    logic            rst_b = 1'b0;
    logic [31:0]     haddr = 32'h0;
    logic [1:0]      htrans = 2'h0;
    logic            hwrite = 1'b0;
    logic [31:0]     hwdata = 32'h0;
    logic [31:0]     hrdata;
    logic            hreadyout;
    logic            hresp;
    logic            cmp;
    logic            sample_hold;
    logic [1:0]      chan;
    logic [9:0]      dac;
    logic            cmp_en;
    logic            end_irq;
    logic            irq;
    logic [3:0][9:0] levels = {10'h155, 10'h000, 10'h3FF, 10'h2A5};
    logic [31:0]     rd;
    int              n_errors = 0;
    int              checks = 0;
    int              cyc = 0;
    int              t0;
    int              per;
    int              n;
    // Row: channel nibble, time field nibble, expected 10-bit result.
    logic [19:0]     rows [4] = '{20'h002A5, 20'h113FF, 20'h22000, 20'h37155};

    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;

    adc_sequencing_control dut
    (
        .ref_clk               (ref_clk),
        .rst_b                 (rst_b),
        .hsel                  (1'b1),
        .haddr                 (haddr),
        .htrans                (htrans),
        .hwrite                (hwrite),
        .hsize                 (3'h2),
        .hwdata                (hwdata),
        .hready                (hreadyout),
        .hrdata                (hrdata),
        .hreadyout             (hreadyout),
        .hresp                 (hresp),
        .comparator_in         (cmp),
        .sample_hold           (sample_hold),
        .analog_input_channels (chan),
        .dac_code              (dac),
        .comparator_enable_bit (cmp_en),
        .conversion_end_irq    (end_irq),
        .irq                   (irq)
    );

    analog_inputs_model far_side
    (
        .ref_clk               (ref_clk),
        .analog_input_channels (chan),
        .dac_code              (dac),
        .comparator_enable_bit (cmp_en),
        .levels                (levels),
        .comparator_in         (cmp)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask

    // Bounded wait for sample_hold (0) or the conversion-end pulse (1).
    task automatic wait_hi(input logic which);
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while ((which ? end_irq : sample_hold) !== 1'b1 && n < 2000);
        chk({31'h0, n < 2000}, 32'h1);
    endtask

    task automatic finish_test;
        $display("Counts: %0d checks, %0d errors", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        finish_test;
    end

    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        for (int a = 0; a < 24; a += 4)
        begin
            bus(1'b0, 8'(a), 32'h0);
            chk(rd, 32'h0);
        end
        bus(1'b1, 8'h08, 32'hFFFFFFFF);
        bus(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        $display("Test reset and map done");
        bus(1'b1, 8'h10, 32'h1);
        bus(1'b1, 8'h00, 32'h81);
        bus(1'b0, 8'h0C, 32'h0);
        chk(rd & 32'h2, 32'h2);
        bus(1'b1, 8'h00, 32'h01);
        bus(1'b1, 8'h0C, 32'h3);
        n = 0;
        do
        begin
            bus(1'b0, 8'h0C, 32'h0);
            n++;
        end
        while (rd[9] !== 1'b1 && n < 1000);
        chk(rd & 32'h203, 32'h200);
        $display("Test settling done");
        foreach (rows[i])
        begin
            bus(1'b1, 8'h04, {30'h0, rows[i][17:16]});
            bus(1'b1, 8'h00, {24'h0, 2'h2, rows[i][14:12], 3'h1});
            wait_hi(1'b0);
            chk({30'h0, chan}, {30'h0, rows[i][17:16]});
            n = 0;
            while (sample_hold === 1'b1)
            begin
                n++;
                @(posedge ref_clk);
            end
            chk(32'(n), 32'(16 * (rows[i][14:12] + 1)));
            wait_hi(1'b1);
            bus(1'b0, 8'h08, 32'h0);
            chk(rd, {22'h0, rows[i][9:0]});
            bus(1'b0, 8'h0C, 32'h0);
            chk(rd & 32'h103, 32'h101);
            chk({31'h0, irq}, 32'h1);
            bus(1'b1, 8'h04, 32'h1);
            bus(1'b0, 8'h0C, 32'h0);
            chk(rd & 32'h1, 32'h1);
            bus(1'b1, 8'h10, 32'h0);
            repeat (2) @(posedge ref_clk);
            chk({31'h0, irq}, 32'h0);
            bus(1'b1, 8'h10, 32'h1);
            bus(1'b1, 8'h00, 32'h01);
            bus(1'b1, 8'h0C, 32'h1);
            bus(1'b0, 8'h0C, 32'h0);
            chk(rd & 32'h101, 32'h0);
            $display("Test row %0d done", i);
        end
        bus(1'b1, 8'h04, 32'h0);
        bus(1'b1, 8'h00, 32'h81);
        wait_hi(1'b1);
        wait_hi(1'b1);
        per = n;
        t0 = cyc;
        levels[0] <= 10'h0F0;
        bus(1'b1, 8'h0C, 32'h1);
        while (cyc < t0 + per - 2)
            @(posedge ref_clk);
        bus(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h2A5);
        bus(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0F0);
        levels[0] <= 10'h10F;
        bus(1'b1, 8'h0C, 32'h1);
        while (cyc < t0 + 2 * per - 3)
            @(posedge ref_clk);
        bus(1'b1, 8'h04, 32'h0);
        n = 0;
        repeat (8)
        begin
            @(posedge ref_clk);
            n += int'(end_irq === 1'b1);
        end
        chk(32'(n), 32'h0);
        bus(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0F0);
        bus(1'b0, 8'h0C, 32'h0);
        chk(rd & 32'h1, 32'h0);
        $display("Test collisions done");
        finish_test;
    end
endmodule
